// ==== src/mpa_pkg.sv ====
package mpa_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int ADR_W = 8;
   localparam logic [7:0] OFS_VOLT_CTRL = 8'h00;
   localparam logic [7:0] OFS_PULSE_CTRL = 8'h04;
   localparam logic [7:0] OFS_PULSE_RATE = 8'h08;
   localparam logic [7:0] OFS_CLASS = 8'h0C;
   localparam logic [7:0] OFS_VOLT_STAT = 8'h10;
   localparam logic [7:0] OFS_PER_STAT = 8'h14;
   localparam int ITEM_LSB = 0;
   localparam int SET_LSB = 8;
   localparam int RATE_LSB = 0;
   localparam int CLASS_LSB = 0;
   typedef enum logic [3:0] {
      ITEM_FREQ_PRE = 4'h0, ITEM_FREQ_POST = 4'h1, ITEM_CURRENT = 4'h2,
      ITEM_VOLT = 4'h3, ITEM_TORQUE = 4'h4, ITEM_LOAD = 4'h5,
      ITEM_POWER = 4'h6, ITEM_PID_FB = 4'h7, ITEM_PG_FB = 4'h8,
      ITEM_LINK = 4'h9, ITEM_AO = 4'hA
   } mpa_item_t;
   localparam logic [3:0] ITEM_MAX = 4'hA;
   localparam logic [7:0] GAIN_MAX = 8'hC8;
   localparam logic [7:0] GAIN_RST = 8'h64;
   localparam logic [7:0] AVG_RST = 8'h00;
   localparam logic [12:0] RATE_MIN = 13'h012C;
   localparam logic [12:0] RATE_MAX = 13'h1770;
   localparam logic [12:0] RATE_RST = 13'h05A0;
   localparam logic [12:0] NORM_FULL = 13'h1000;
   localparam logic [12:0] NORM_SAT = 13'h1FFF;
   localparam int FS_FREQ_PM = 1000;
   localparam int FS_RATED_PM = 2000;
   localparam int FS_VOLT_LO = 250;
   localparam int FS_VOLT_HI = 500;
   localparam int FS_LINK_LO = 500;
   localparam int FS_LINK_HI = 1000;
   localparam int FS_AO_MV = 10000;
   localparam int KSH = 20;
   localparam int NSH = KSH - 12;
   localparam logic [19:0] K_FREQ = 20'(((1 << KSH) + FS_FREQ_PM - 1) / FS_FREQ_PM);
   localparam logic [19:0] K_RATED = 20'(((1 << KSH) + FS_RATED_PM - 1) / FS_RATED_PM);
   localparam logic [19:0] K_VOLT_LO = 20'(((1 << KSH) + FS_VOLT_LO - 1) / FS_VOLT_LO);
   localparam logic [19:0] K_VOLT_HI = 20'(((1 << KSH) + FS_VOLT_HI - 1) / FS_VOLT_HI);
   localparam logic [19:0] K_LINK_LO = 20'(((1 << KSH) + FS_LINK_LO - 1) / FS_LINK_LO);
   localparam logic [19:0] K_LINK_HI = 20'(((1 << KSH) + FS_LINK_HI - 1) / FS_LINK_HI);
   localparam logic [19:0] K_AO = 20'(((1 << KSH) + FS_AO_MV - 1) / FS_AO_MV);
   localparam int PCT_FULL = 100;
   localparam int PCT_SH = 24;
   localparam logic [17:0] PCT_K = 18'(((1 << PCT_SH) + PCT_FULL - 1) / PCT_FULL);
   localparam int PULSE_FIX_PPS = 2670;
   localparam logic [31:0] PER_FIX = 32'(CLK_HZ / PULSE_FIX_PPS);
   localparam logic [31:0] PER_MIN = 32'(CLK_HZ / 6000);
   localparam longint AVG_MAX_DV = 156;
   localparam longint VFS_DV = 100;
   localparam int HI_SH = 16;
   localparam logic [15:0] HI_K = 16'((longint'(PER_FIX) * VFS_DV * (64'd1 << HI_SH))
      / (AVG_MAX_DV * PCT_FULL * 4096));
   localparam int NUM_W = 38;
   localparam logic [NUM_W-1:0] DIV_NUM = NUM_W'(longint'(CLK_HZ) * 4096);
   localparam int DEN_W = 27;
   localparam logic [5:0] DIV_STEPS = 6'h26;
   typedef enum logic [1:0] {
      DIV_IDLE = 2'b00,
      DIV_RUN = 2'b01,
      DIV_DONE = 2'b11
   } mpa_div_t;
endpackage

// ==== src/mpa_monitor_out.sv ====
`timescale 1ns/10ps
`default_nettype none
module mpa_monitor_out
   import mpa_pkg::*;
#(
   parameter int VOUT_W = 16
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [mpa_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [15:0] mon_freq_pre,
   input wire logic [15:0] mon_freq_post,
   input wire logic [15:0] mon_current,
   input wire logic [15:0] mon_voltage,
   input wire logic [15:0] mon_torque,
   input wire logic [15:0] mon_load,
   input wire logic [15:0] mon_power,
   input wire logic [15:0] mon_pid_fb,
   input wire logic [15:0] mon_pg_fb,
   input wire logic [15:0] mon_link_volt,
   input wire logic [15:0] mon_univ_ao,
   output logic [VOUT_W-1:0] voltage_meter_out,
   output logic pulse_meter_out
);
   import mpa_pkg::*;

   generate
      if (VOUT_W < 14 || VOUT_W > 32)
      begin : g_chk
         $error("VOUT_W must lie in 14..32");
      end
   endgenerate

   logic [3:0] vitem_reg;
   logic [7:0] voltage_meter_gain;
   logic [3:0] pitem_reg;
   logic [7:0] pulse_meter_avg_volt_set;
   logic [12:0] pulse_meter_max_rate;
   logic hv_class_reg;
   logic ack_reg;
   logic [31:0] dat_reg;
   logic [12:0] vnorm_reg;
   logic [12:0] pnorm_reg;
   logic [VOUT_W-1:0] vout_reg;
   logic [15:0] mon [0:10];
   logic wr_en;
   logic [31:0] rd_data;
   logic [31:0] wval;
   logic [31:0] per_reg;

   assign mon[0] = mon_freq_pre;
   assign mon[1] = mon_freq_post;
   assign mon[2] = mon_current;
   assign mon[3] = mon_voltage;
   assign mon[4] = mon_torque;
   assign mon[5] = mon_load;
   assign mon[6] = mon_power;
   assign mon[7] = mon_pid_fb;
   assign mon[8] = mon_pg_fb;
   assign mon[9] = mon_link_volt;
   assign mon[10] = mon_univ_ao;

   // byte-lane merge of a write into a register image
   function automatic logic [31:0] wmerge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // monitor value to fraction of full scale, 4096 = 100 %
   function automatic logic [12:0] norm(input logic [3:0] item,
      input logic [15:0] v, input logic hv);
      logic [19:0] k;
      logic [35:0] p;
      k = K_AO;
      p = '0;
      case (item)
         ITEM_FREQ_PRE, ITEM_FREQ_POST, ITEM_PID_FB, ITEM_PG_FB: k = K_FREQ;
         ITEM_CURRENT, ITEM_TORQUE, ITEM_LOAD, ITEM_POWER: k = K_RATED;
         ITEM_VOLT: k = hv ? K_VOLT_HI : K_VOLT_LO;
         ITEM_LINK: k = hv ? K_LINK_HI : K_LINK_LO;
         default: k = K_AO;
      endcase
      p = (36'(v) * 36'(k)) >> NSH;
      return (p > 36'(NORM_SAT)) ? NORM_SAT : p[12:0];
   endfunction

   // bus slave
   // write lands on the edge that sees ack high
   assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;

   always_comb
   begin
      rd_data = '0;
      case (wb_adr_i)
         OFS_VOLT_CTRL: rd_data = {16'h0000, voltage_meter_gain, 4'h0, vitem_reg};
         OFS_PULSE_CTRL: rd_data = {16'h0000, pulse_meter_avg_volt_set, 4'h0, pitem_reg};
         OFS_PULSE_RATE: rd_data = {19'h00000, pulse_meter_max_rate};
         OFS_CLASS: rd_data = {31'h00000000, hv_class_reg};
         OFS_VOLT_STAT: rd_data = 32'(vout_reg);
         OFS_PER_STAT: rd_data = per_reg;
         default: rd_data = '0;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ack_reg <= 1'b0;
         dat_reg <= '0;
      end
      else
      begin
         ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
         if (wb_cyc_i && wb_stb_i && !ack_reg)
         begin
            dat_reg <= rd_data;
         end
      end
   end

   assign wval = wmerge(rd_data, wb_dat_i, wb_sel_i);

   // settings; out-of-range values are refused field by field
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         vitem_reg <= ITEM_FREQ_PRE;
         voltage_meter_gain <= GAIN_RST;
         pitem_reg <= ITEM_FREQ_PRE;
         pulse_meter_avg_volt_set <= AVG_RST;
         pulse_meter_max_rate <= RATE_RST;
         hv_class_reg <= 1'b0;
      end
      else if (wr_en)
      begin
         if (wb_adr_i == OFS_VOLT_CTRL)
         begin
            if (wval[ITEM_LSB +: 4] <= ITEM_MAX)
            begin
               vitem_reg <= wval[ITEM_LSB +: 4];
            end
            if (wval[SET_LSB +: 8] <= GAIN_MAX)
            begin
               voltage_meter_gain <= wval[SET_LSB +: 8];
            end
         end
         if (wb_adr_i == OFS_PULSE_CTRL)
         begin
            if (wval[ITEM_LSB +: 4] <= ITEM_MAX)
            begin
               pitem_reg <= wval[ITEM_LSB +: 4];
            end
            if (wval[SET_LSB +: 8] <= GAIN_MAX)
            begin
               pulse_meter_avg_volt_set <= wval[SET_LSB +: 8];
            end
         end
         if (wb_adr_i == OFS_PULSE_RATE && wval[RATE_LSB +: 13] >= RATE_MIN
            && wval[RATE_LSB +: 13] <= RATE_MAX)
         begin
            pulse_meter_max_rate <= wval[RATE_LSB +: 13];
         end
         if (wb_adr_i == OFS_CLASS)
         begin
            hv_class_reg <= wval[CLASS_LSB];
         end
      end
   end

   // normalised quantities and scaled dc level
   logic [47:0] vprod;
   assign vprod = 48'(vnorm_reg) * 48'(voltage_meter_gain) * 48'(PCT_K);

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         vnorm_reg <= '0;
         pnorm_reg <= '0;
         vout_reg <= '0;
      end
      else
      begin
         vnorm_reg <= norm(vitem_reg, mon[vitem_reg], hv_class_reg);
         pnorm_reg <= norm(pitem_reg, mon[pitem_reg], hv_class_reg);
         vout_reg <= VOUT_W'(vprod >> PCT_SH);
      end
   end

   // pulse generator
   mpa_div_t div_state;
   logic [5:0] div_cnt_reg;
   logic [NUM_W-1:0] div_num_reg;
   logic [DEN_W-1:0] div_den_reg;
   logic [DEN_W-1:0] div_rem_reg;
   logic [DEN_W:0] trial;
   logic fixed_reg;
   logic [31:0] fix_high_reg;
   logic [31:0] cnt_reg;
   logic [31:0] high_reg;
   logic [31:0] nxt_per_reg;
   logic [31:0] nxt_high_reg;
   logic [12:0] pn_cap;
   logic [31:0] fix_high;
   logic [31:0] quot;
   logic per_end;
   logic pulse_reg;

   assign pn_cap = (pnorm_reg > NORM_FULL) ? NORM_FULL : pnorm_reg;
   assign fix_high = 32'((40'(pnorm_reg) * 40'(pulse_meter_avg_volt_set)
      * 40'(HI_K)) >> HI_SH);
   assign trial = {div_rem_reg, div_num_reg[NUM_W-1]};
   assign quot = div_num_reg[31:0];
   assign per_end = (cnt_reg >= per_reg - 32'h00000001);

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         div_state <= DIV_IDLE;
         div_cnt_reg <= '0;
         div_num_reg <= '0;
         div_den_reg <= '0;
         div_rem_reg <= '0;
         fixed_reg <= 1'b1;
         fix_high_reg <= '0;
         nxt_per_reg <= PER_FIX;
         nxt_high_reg <= '0;
      end
      else
      begin
         unique case (div_state)
            DIV_IDLE:
            begin
               if (cnt_reg == '0)
               begin
                  div_num_reg <= DIV_NUM;
                  div_den_reg <= DEN_W'(pn_cap) * DEN_W'(pulse_meter_max_rate);
                  div_rem_reg <= '0;
                  div_cnt_reg <= DIV_STEPS;
                  fixed_reg <= (pulse_meter_avg_volt_set != '0);
                  fix_high_reg <= (fix_high > PER_FIX) ? PER_FIX : fix_high;
                  div_state <= DIV_RUN;
               end
            end
            DIV_RUN:
            begin
               if (trial >= {1'b0, div_den_reg})
               begin
                  div_rem_reg <= DEN_W'(trial - {1'b0, div_den_reg});
                  div_num_reg <= {div_num_reg[NUM_W-2:0], 1'b1};
               end
               else
               begin
                  div_rem_reg <= trial[DEN_W-1:0];
                  div_num_reg <= {div_num_reg[NUM_W-2:0], 1'b0};
               end
               div_cnt_reg <= div_cnt_reg - 6'h01;
               if (div_cnt_reg == 6'h01)
               begin
                  div_state <= DIV_DONE;
               end
            end
            DIV_DONE:
            begin
               if (fixed_reg)
               begin
                  nxt_per_reg <= PER_FIX;
                  nxt_high_reg <= fix_high_reg;
               end
               else if (div_den_reg == '0)
               begin
                  nxt_per_reg <= PER_FIX;
                  nxt_high_reg <= '0;
               end
               else
               begin
                  nxt_per_reg <= quot;
                  nxt_high_reg <= quot >> 1;
               end
               div_state <= DIV_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_reg <= '0;
         per_reg <= PER_FIX;
         high_reg <= '0;
         pulse_reg <= 1'b0;
      end
      else
      begin
         if (per_end)
         begin
            cnt_reg <= '0;
            per_reg <= nxt_per_reg;
            high_reg <= nxt_high_reg;
            pulse_reg <= (nxt_high_reg != '0);
         end
         else
         begin
            cnt_reg <= cnt_reg + 32'h00000001;
            pulse_reg <= (cnt_reg + 32'h00000001 < high_reg);
         end
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;
   assign voltage_meter_out = vout_reg;
   assign pulse_meter_out = pulse_reg;

   // checks
   sequence s_div_start;
      div_state == DIV_IDLE && cnt_reg == '0;
   endsequence
   sequence s_div_end;
      div_state == DIV_DONE;
   endsequence

   a_item_range: assert property (@(posedge clk) disable iff (!arst_n)
      vitem_reg <= ITEM_MAX && pitem_reg <= ITEM_MAX)
      else $error("item code out of range");
   a_gain_range: assert property (@(posedge clk) disable iff (!arst_n)
      voltage_meter_gain <= GAIN_MAX)
      else $error("gain out of range");
   a_zero_gain: assert property (@(posedge clk) disable iff (!arst_n)
      (voltage_meter_gain == '0) [*3] |-> voltage_meter_out == '0)
      else $error("zero gain gives nonzero level");
   a_rate_range: assert property (@(posedge clk) disable iff (!arst_n)
      pulse_meter_max_rate >= RATE_MIN && pulse_meter_max_rate <= RATE_MAX)
      else $error("pulse rate setting out of range");
   a_rate_cap: assert property (@(posedge clk) disable iff (!arst_n)
      per_reg >= PER_MIN)
      else $error("pulse rate above maximum");
   a_fixed_period: assert property (@(posedge clk) disable iff (!arst_n)
      s_div_end ##0 fixed_reg |=> nxt_per_reg == PER_FIX)
      else $error("fixed mode period wrong");
   a_high_fits: assert property (@(posedge clk) disable iff (!arst_n)
      high_reg <= per_reg)
      else $error("high time longer than period");
   a_div_bound: assert property (@(posedge clk) disable iff (!arst_n)
      s_div_start |=> ##[38:40] s_div_end)
      else $error("period recompute late");
   a_pulse_start: assert property (@(posedge clk) disable iff (!arst_n)
      per_end && nxt_high_reg != '0 |=> pulse_meter_out && cnt_reg == '0)
      else $error("pulse did not start with period");
endmodule
`default_nettype wire

// ==== dv/mpa_meter_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// counter instrument on the pulse meter line
module mpa_meter_model
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic pulse_in,
   output logic [31:0] per_cnt,
   output logic [31:0] hi_cnt,
   output logic tick
);
   logic prev_reg;
   logic [31:0] run_reg;
   logic [31:0] hrun_reg;
   // period is rise to rise, high time counted inside it
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         prev_reg <= 1'b0;
         run_reg <= 32'h0;
         hrun_reg <= 32'h0;
         per_cnt <= 32'h0;
         hi_cnt <= 32'h0;
         tick <= 1'b0;
      end
      else
      begin
         prev_reg <= pulse_in;
         tick <= 1'b0;
         if (pulse_in && !prev_reg)
         begin
            per_cnt <= run_reg;
            hi_cnt <= hrun_reg;
            tick <= 1'b1;
            run_reg <= 32'h1;
            hrun_reg <= 32'h1;
         end
         else
         begin
            run_reg <= run_reg + 32'h1;
            hrun_reg <= hrun_reg + {31'h0, pulse_in};
         end
      end
   end
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import mpa_pkg::*;
   logic clk, arst_n, cyc, stb, we, ack, pulse, tick;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] dat_i, dat_o, seed, per_cnt, hi_cnt, d, p, h;
   logic [15:0] vout;
   logic [15:0] mon [0:10];
   int failures, cmp_count, c, i, g;
   logic hv;
   longint e;

   mpa_monitor_out dut_u (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .mon_freq_pre(mon[0]), .mon_freq_post(mon[1]), .mon_current(mon[2]),
      .mon_voltage(mon[3]), .mon_torque(mon[4]), .mon_load(mon[5]),
      .mon_power(mon[6]), .mon_pid_fb(mon[7]), .mon_pg_fb(mon[8]),
      .mon_link_volt(mon[9]), .mon_univ_ao(mon[10]),
      .voltage_meter_out(vout), .pulse_meter_out(pulse));

   mpa_meter_model meter_u (.clk(clk), .arst_n(arst_n), .pulse_in(pulse),
      .per_cnt(per_cnt), .hi_cnt(hi_cnt), .tick(tick));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // full scale of each item in input units
   function automatic int fs(input int code, input logic hi);
      case (code)
         0, 1, 7, 8: fs = FS_FREQ_PM;
         3: fs = hi ? FS_VOLT_HI : FS_VOLT_LO;
         9: fs = hi ? FS_LINK_HI : FS_LINK_LO;
         10: fs = FS_AO_MV;
         default: fs = FS_RATED_PM;
      endcase
   endfunction

   task automatic test_done();
      if (failures == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
      input int tol);
      logic [31:0] df;
      df = (seen > exp) ? seen - exp : exp - seen;
      cmp_count++;
      if (seen !== exp && ((^seen === 1'bx) || df > 32'(tol)))
      begin
         failures++;
         $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask

   task automatic wb_go(input logic [7:0] a, input logic w,
      input logic [31:0] wd, input logic [3:0] s, output logic [31:0] rd);
      int t;
      t = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_i <= wd;
      sel <= s;
      do
      begin
         @(posedge clk);
         t++;
      end
      while (ack !== 1'b1 && t < 16);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
      if (t >= 16)
      begin
         failures++;
         test_done();
      end
   endtask

   task automatic wb_wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] r;
      wb_go(a, 1'b1, wd, 4'hF, r);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      wb_go(a, 1'b0, 32'h0, 4'hF, r);
      chk(r, exp, 0);
   endtask

   task automatic wait_ticks(input int n);
      int k;
      k = 0;
      while (k < n && $time < 64'h1E3660)
      begin
         @(posedge clk);
         if (tick === 1'b1)
            k++;
      end
      p = per_cnt;
      h = hi_cnt;
      if (k < n)
      begin
         failures++;
         test_done();
      end
   endtask

   initial
   begin
      seed = 32'h30;
      failures = 0;
      cmp_count = 0;
      arst_n = 1'b0;
      {cyc, stb, we} = 3'h0;
      adr = 8'h00;
      sel = 4'h0;
      dat_i = 32'h0;
      for (i = 0; i < 11; i++)
         mon[i] = 16'h0;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      // defaults and idle pulse line
      rd_chk(OFS_VOLT_CTRL, 32'h6400);
      rd_chk(OFS_PULSE_CTRL, 32'h0);
      rd_chk(OFS_PULSE_RATE, 32'h5A0);
      rd_chk(OFS_PER_STAT, 32'(CLK_HZ / 2670));
      chk({31'h0, pulse}, 32'h0, 0);
      // out of range fields are kept, edge values taken
      wb_wr(OFS_VOLT_CTRL, 32'hC90B);
      rd_chk(OFS_VOLT_CTRL, 32'h6400);
      wb_wr(OFS_VOLT_CTRL, 32'hC80A);
      rd_chk(OFS_VOLT_CTRL, 32'hC80A);
      wb_go(OFS_VOLT_CTRL, 1'b1, 32'h3205, 4'h2, d);
      rd_chk(OFS_VOLT_CTRL, 32'h320A);
      wb_wr(OFS_PULSE_RATE, 32'h12B);
      rd_chk(OFS_PULSE_RATE, 32'h5A0);
      wb_wr(OFS_PULSE_RATE, 32'h1771);
      rd_chk(OFS_PULSE_RATE, 32'h5A0);
      wb_wr(OFS_PULSE_RATE, 32'h12C);
      rd_chk(OFS_PULSE_RATE, 32'h12C);
      wb_wr(OFS_PULSE_RATE, 32'h1770);
      rd_chk(OFS_PULSE_RATE, 32'h1770);
      wb_wr(OFS_PULSE_CTRL, 32'hC900);
      rd_chk(OFS_PULSE_CTRL, 32'h0);
      wb_wr(OFS_PULSE_CTRL, 32'hC80B);
      rd_chk(OFS_PULSE_CTRL, 32'hC800);
      wb_wr(8'h18, 32'hFFFF);
      rd_chk(8'h18, 32'h0);
      // every item code through the voltage meter
      for (c = 0; c < 11; c++)
      begin
         hv = 1'(xs() & 32'h1);
         g = (c == 0) ? 200 : (c == 1) ? 0 : int'(xs() % 201);
         for (i = 0; i < 11; i++)
            mon[i] <= 16'(xs() % 32'(fs(i, hv) + 1));
         wb_wr(OFS_CLASS, {31'h0, hv});
         rd_chk(OFS_CLASS, {31'h0, hv});
         wb_wr(OFS_VOLT_CTRL, 32'((g << 8) | c));
         if (c == 2)
            mon[c] <= 16'(fs(c, hv));
         repeat (8) @(posedge clk);
         e = longint'(mon[c]) * 4096 * g / (fs(c, hv) * 100);
         chk({16'h0, vout}, 32'(e), int'(e / 256) + 4);
         wb_go(OFS_VOLT_STAT, 1'b0, 32'h0, 4'hF, d);
         chk(d, 32'(e), int'(e / 256) + 4);
      end
      // rate mode, quantity above full scale is capped
      mon[0] <= 16'h05DC;
      wb_wr(OFS_PULSE_CTRL, 32'h0);
      wait_ticks(3);
      e = CLK_HZ / 6000;
      chk(p, 32'(e), 2);
      chk(h, 32'(e / 2), 2);
      rd_chk(OFS_PER_STAT, 32'(e));
      // average mode, half of full scale current at 100 percent
      mon[2] <= 16'h03E8;
      wb_wr(OFS_PULSE_CTRL, 32'h6402);
      wait_ticks(3);
      e = CLK_HZ / 2670;
      chk(p, 32'(e), 1);
      e = e * 100 * 2048 / (156 * 4096);
      chk(h, 32'(e), int'(e / 128) + 4);
      test_done();
   end
endmodule
`default_nettype wire
